// ===== dssa_map.svh
// register indices, field positions and reset values of the display block
`ifndef DSSA_MAP_SVH
`define DSSA_MAP_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define DSSA_IDX_VSIZE_LO 16'hFFE5
`define DSSA_IDX_VSIZE_HI 16'hFFE6
`define DSSA_IDX_ALT_RATE 16'hFFEB
`define DSSA_IDX_S1_LO 16'hFFEC
`define DSSA_IDX_S1_HI 16'hFFED
`define DSSA_IDX_S2_LO 16'hFFEF
`define DSSA_IDX_S2_HI 16'hFFF0
`define DSSA_IDX_OFFSET 16'hFFF2
`define DSSA_IDX_H1_LO 16'hFFF3
`define DSSA_IDX_H1_HI 16'hFFF4
`define DSSA_IDX_LUT_PTR 16'hFFF5
`define DSSA_IDX_LUT_DATA 16'hFFF7
`define DSSA_IDX_CTRL 16'hFFFC
`define DSSA_IDX_STATUS 16'hFFFD
`define DSSA_ADDR_W 18

// =====================================================================
// field positions
`define DSSA_CTRL_TFT 0
`define DSSA_CTRL_ROT 1
`define DSSA_STAT_ALT 0
`define DSSA_STAT_BLANK 1
`define DSSA_STAT_LINE_LSB 2
`define DSSA_PTR_SEL_LSB 4
`define DSSA_ADDR_MSB 15

// =====================================================================
// reset values and responses
`define DSSA_RST_H1 10'h000
`define DSSA_RST_VSIZE 10'h000
`define DSSA_RST_RATE 6'h00
`define DSSA_RST_ADDR 16'h0000
`define DSSA_RST_OFFSET 8'h00
`define DSSA_RESP_OKAY 2'h0
`define DSSA_RESP_SLVERR 2'h2
`define DSSA_SEL_AUTO 2'h0
`define DSSA_SEL_RED 2'h1
`define DSSA_SEL_GREEN 2'h2

`endif

// ===== dssa_pkg.sv
// types shared by the display addressing block
package dssa_pkg;
   typedef enum {LUT_RED, LUT_GREEN, LUT_BLUE} dssa_phase_t;

   typedef struct packed {
      logic framePulse;
      logic linePulse;
      logic altDrive;
      logic [11:0] pixel;
   } dssa_panel_t;

   typedef struct packed {
      logic fetchValid;
      logic [15:0] fetchAddr;
   } dssa_fetch_t;
endpackage

// ===== dssa_display.sv
// refresh addressing, split screen, alternating drive and colour tables
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dssa_map.svh"

module dssa_display #(
   parameter int LINE_CYCLES = 64,
   parameter int ACTIVE_WORDS = 40,
   parameter int LINE_BYTES = 80,
   parameter int VBLANK_LINES = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`DSSA_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`DSSA_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] pixelIndex,
   output dssa_pkg::dssa_panel_t panel,
   output dssa_pkg::dssa_fetch_t fetch
);

   // =================================================================
   // register state
   logic [5:0] altRate_q;
   logic [15:0] s1Start_q;
   logic [15:0] s2Start_q;
   logic [7:0] lineOffset_q;
   logic [9:0] s1Height_q;
   logic [9:0] vSize_q;
   logic [1:0] lutSel_q;
   logic [3:0] lutIdx_q;
   logic tftMode_q;
   logic rotated_q;
   dssa_pkg::dssa_phase_t phase_q;
   logic [3:0] lutRed [16];
   logic [3:0] lutGreen [16];
   logic [3:0] lutBlue [16];

   // =================================================================
   // bus slave: address and data latched independently
   logic awHave_q;
   logic wHave_q;
   logic [15:0] wIdx_q;
   logic [7:0] wByte_q;
   logic wLane_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wrEn;
   logic rdEn;
   logic [15:0] rIdx;
   logic [31:0] rdMux;
   logic rdHit;
   logic wrHit;
   logic lutTouch;

   assign s_axi_awready = !awHave_q;
   assign s_axi_wready = !wHave_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign wrEn = awHave_q && wHave_q && !bvalid_q;
   assign rdEn = s_axi_arvalid && !rvalid_q;
   assign rIdx = s_axi_araddr[`DSSA_ADDR_W-1:2];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awHave_q <= 1'b0;
         wIdx_q <= 16'h0000;
      end else if (s_axi_awvalid && !awHave_q) begin
         awHave_q <= 1'b1;
         wIdx_q <= s_axi_awaddr[`DSSA_ADDR_W-1:2];
      end else if (wrEn) begin
         awHave_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wHave_q <= 1'b0;
         wByte_q <= 8'h00;
         wLane_q <= 1'b0;
      end else if (s_axi_wvalid && !wHave_q) begin
         wHave_q <= 1'b1;
         wByte_q <= s_axi_wdata[7:0];
         wLane_q <= s_axi_wstrb[0];
      end else if (wrEn) begin
         wHave_q <= 1'b0;
      end
   end

   always_comb begin
      wrHit = 1'b1;
      unique case (wIdx_q)
         `DSSA_IDX_VSIZE_LO, `DSSA_IDX_VSIZE_HI, `DSSA_IDX_ALT_RATE,
         `DSSA_IDX_S1_LO, `DSSA_IDX_S1_HI, `DSSA_IDX_S2_LO,
         `DSSA_IDX_S2_HI, `DSSA_IDX_OFFSET, `DSSA_IDX_H1_LO,
         `DSSA_IDX_H1_HI, `DSSA_IDX_LUT_PTR, `DSSA_IDX_LUT_DATA,
         `DSSA_IDX_CTRL, `DSSA_IDX_STATUS: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q <= `DSSA_RESP_OKAY;
      end else if (wrEn) begin
         bvalid_q <= 1'b1;
         bresp_q <= wrHit ? `DSSA_RESP_OKAY : `DSSA_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // the byte that software writes; lane 0 gates every register
   logic wrGo;
   assign wrGo = wrEn && wLane_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         altRate_q <= `DSSA_RST_RATE;
         s1Start_q <= `DSSA_RST_ADDR;
         s2Start_q <= `DSSA_RST_ADDR;
         lineOffset_q <= `DSSA_RST_OFFSET;
         s1Height_q <= `DSSA_RST_H1;
         vSize_q <= `DSSA_RST_VSIZE;
         tftMode_q <= 1'b0;
         rotated_q <= 1'b0;
      end else if (wrGo) begin
         unique case (wIdx_q)
            `DSSA_IDX_VSIZE_LO: vSize_q[7:0] <= wByte_q;
            `DSSA_IDX_VSIZE_HI: vSize_q[9:8] <= wByte_q[1:0];
            `DSSA_IDX_ALT_RATE: altRate_q <= wByte_q[5:0];
            `DSSA_IDX_S1_LO: s1Start_q[7:0] <= wByte_q;
            `DSSA_IDX_S1_HI: s1Start_q[15:8] <= wByte_q;
            `DSSA_IDX_S2_LO: s2Start_q[7:0] <= wByte_q;
            `DSSA_IDX_S2_HI: s2Start_q[15:8] <= wByte_q;
            `DSSA_IDX_OFFSET: lineOffset_q <= wByte_q;
            `DSSA_IDX_H1_LO: s1Height_q[7:0] <= wByte_q;
            `DSSA_IDX_H1_HI: s1Height_q[9:8] <= wByte_q[1:0];
            `DSSA_IDX_CTRL: begin
               tftMode_q <= wByte_q[`DSSA_CTRL_TFT];
               rotated_q <= wByte_q[`DSSA_CTRL_ROT];
            end
            default: ;
         endcase
      end
   end

   // =================================================================
   // colour tables and the aperture pointer
   logic [1:0] lutTable;
   logic [3:0] lutRdData;

   always_comb begin
      lutTable = lutSel_q;
      if (lutSel_q == `DSSA_SEL_AUTO) begin
         unique case (phase_q)
            dssa_pkg::LUT_RED: lutTable = `DSSA_SEL_RED;
            dssa_pkg::LUT_GREEN: lutTable = `DSSA_SEL_GREEN;
            dssa_pkg::LUT_BLUE: lutTable = 2'h3;
         endcase
      end
      unique case (lutTable)
         `DSSA_SEL_RED: lutRdData = lutRed[lutIdx_q];
         `DSSA_SEL_GREEN: lutRdData = lutGreen[lutIdx_q];
         default: lutRdData = lutBlue[lutIdx_q];
      endcase
   end

   // tables carry no reset; contents are undefined until loaded
   always_ff @(posedge clk) begin
      if (wrGo && wIdx_q == `DSSA_IDX_LUT_DATA) begin
         unique case (lutTable)
            `DSSA_SEL_RED: lutRed[lutIdx_q] <= wByte_q[3:0];
            `DSSA_SEL_GREEN: lutGreen[lutIdx_q] <= wByte_q[3:0];
            default: lutBlue[lutIdx_q] <= wByte_q[3:0];
         endcase
      end
   end

   // a write and a read of the aperture in one cycle advance it once
   assign lutTouch = (wrGo && wIdx_q == `DSSA_IDX_LUT_DATA) ||
      (rdEn && rIdx == `DSSA_IDX_LUT_DATA);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lutSel_q <= `DSSA_SEL_AUTO;
         lutIdx_q <= 4'h0;
         phase_q <= dssa_pkg::LUT_RED;
      end else if (wrGo && wIdx_q == `DSSA_IDX_LUT_PTR) begin
         lutSel_q <= wByte_q[`DSSA_PTR_SEL_LSB+1:`DSSA_PTR_SEL_LSB];
         lutIdx_q <= wByte_q[3:0];
         phase_q <= dssa_pkg::LUT_RED;
      end else if (lutTouch) begin
         if (lutSel_q == `DSSA_SEL_AUTO) begin
            unique case (phase_q)
               dssa_pkg::LUT_RED: phase_q <= dssa_pkg::LUT_GREEN;
               dssa_pkg::LUT_GREEN: phase_q <= dssa_pkg::LUT_BLUE;
               dssa_pkg::LUT_BLUE: begin
                  phase_q <= dssa_pkg::LUT_RED;
                  lutIdx_q <= lutIdx_q + 4'h1;
               end
            endcase
         end else begin
            lutIdx_q <= lutIdx_q + 4'h1;
         end
      end
   end

   // =================================================================
   // panel timing
   logic [15:0] hCnt_q;
   logic [10:0] vCnt_q;
   logic [10:0] vLast;
   logic [10:0] vNext;
   logic lineEnd;
   logic frameEnd;
   logic inBlank;
   logic altOut_q;

   assign vLast = {1'b0, vSize_q} + 11'(VBLANK_LINES);
   assign lineEnd = hCnt_q == 16'(LINE_CYCLES - 1);
   assign frameEnd = lineEnd && vCnt_q == vLast;
   assign vNext = (vCnt_q == vLast) ? 11'h000 : vCnt_q + 11'h001;
   assign inBlank = vCnt_q > {1'b0, vSize_q};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hCnt_q <= 16'h0000;
         vCnt_q <= 11'h000;
      end else if (lineEnd) begin
         hCnt_q <= 16'h0000;
         vCnt_q <= vNext;
      end else begin
         hCnt_q <= hCnt_q + 16'h0001;
      end
   end

   // =================================================================
   // refresh addressing with split screen
   logic [15:0] s1Eff;
   logic [15:0] s2Eff;
   logic [15:0] lineStep;
   logic splitHere;
   logic [15:0] lineStart_q;
   logic [15:0] fetchAddr_q;
   logic fetchValid_q;

   // bit 15 only counts when rotated
   assign s1Eff = rotated_q ? s1Start_q :
      {1'b0, s1Start_q[`DSSA_ADDR_MSB-1:0]};
   assign s2Eff = rotated_q ? s2Start_q :
      {1'b0, s2Start_q[`DSSA_ADDR_MSB-1:0]};
   assign lineStep = rotated_q ? 16'(LINE_BYTES) :
      16'(ACTIVE_WORDS) + {8'h00, lineOffset_q};
   assign splitHere = !rotated_q && s1Height_q < vSize_q &&
      vNext == {1'b0, s1Height_q} + 11'h001;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lineStart_q <= `DSSA_RST_ADDR;
      end else if (lineEnd) begin
         if (vNext == 11'h000) begin
            lineStart_q <= s1Eff;
         end else if (splitHere) begin
            lineStart_q <= s2Eff;
         end else begin
            lineStart_q <= lineStart_q + lineStep;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fetchAddr_q <= `DSSA_RST_ADDR;
         fetchValid_q <= 1'b0;
      end else begin
         fetchValid_q <= !inBlank && hCnt_q < 16'(ACTIVE_WORDS);
         fetchAddr_q <= (hCnt_q == 16'h0000) ? lineStart_q :
            fetchAddr_q + 16'h0001;
      end
   end

   // =================================================================
   // alternating drive
   logic [5:0] altCnt_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         altOut_q <= 1'b0;
         altCnt_q <= 6'h00;
      end else if (tftMode_q) begin
         // cleared at a line edge so the pin never moves off a pulse
         altCnt_q <= 6'h00;
         if (lineEnd) begin
            altOut_q <= 1'b0;
         end
      end else if (altRate_q == 6'h00) begin
         altCnt_q <= 6'h00;
         if (frameEnd) begin
            altOut_q <= !altOut_q;
         end
      end else if (lineEnd) begin
         if (altCnt_q >= altRate_q) begin
            altCnt_q <= 6'h00;
            altOut_q <= !altOut_q;
         end else begin
            altCnt_q <= altCnt_q + 6'h01;
         end
      end
   end

   // =================================================================
   // panel outputs, all registered
   logic framePulse_q;
   logic linePulse_q;
   logic [11:0] pixel_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         framePulse_q <= 1'b0;
         linePulse_q <= 1'b0;
         pixel_q <= 12'h000;
      end else begin
         framePulse_q <= frameEnd;
         linePulse_q <= lineEnd;
         pixel_q <= {lutRed[pixelIndex], lutGreen[pixelIndex],
            lutBlue[pixelIndex]};
      end
   end

   assign panel = '{framePulse: framePulse_q, linePulse: linePulse_q,
      altDrive: altOut_q, pixel: pixel_q};
   assign fetch = '{fetchValid: fetchValid_q, fetchAddr: fetchAddr_q};

   // =================================================================
   // read path
   always_comb begin
      rdMux = 32'h0000_0000;
      rdHit = 1'b1;
      unique case (rIdx)
         `DSSA_IDX_VSIZE_LO: rdMux[7:0] = vSize_q[7:0];
         `DSSA_IDX_VSIZE_HI: rdMux[1:0] = vSize_q[9:8];
         `DSSA_IDX_ALT_RATE: rdMux[5:0] = altRate_q;
         `DSSA_IDX_S1_LO: rdMux[7:0] = s1Start_q[7:0];
         `DSSA_IDX_S1_HI: rdMux[7:0] = s1Start_q[15:8];
         `DSSA_IDX_S2_LO: rdMux[7:0] = s2Start_q[7:0];
         `DSSA_IDX_S2_HI: rdMux[7:0] = s2Start_q[15:8];
         `DSSA_IDX_OFFSET: rdMux[7:0] = lineOffset_q;
         `DSSA_IDX_H1_LO: rdMux[7:0] = s1Height_q[7:0];
         `DSSA_IDX_H1_HI: rdMux[1:0] = s1Height_q[9:8];
         `DSSA_IDX_LUT_PTR: rdMux[5:0] = {lutSel_q, lutIdx_q};
         `DSSA_IDX_LUT_DATA: rdMux[3:0] = lutRdData;
         `DSSA_IDX_CTRL: rdMux[1:0] = {rotated_q, tftMode_q};
         `DSSA_IDX_STATUS: rdMux[12:0] = {vCnt_q, inBlank, altOut_q};
         default: rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `DSSA_RESP_OKAY;
      end else if (rdEn) begin
         rvalid_q <= 1'b1;
         rdata_q <= rdMux;
         rresp_q <= rdHit ? `DSSA_RESP_OKAY : `DSSA_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule // dssa_display

// ===== dssa_display_checker.sv
// port checks for the display addressing block
`timescale 1ns/1ps
module dssa_display_checker #(
   parameter int LINE_CYCLES = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire dssa_pkg::dssa_panel_t panel,
   input wire dssa_pkg::dssa_fetch_t fetch
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ======
   // line period: counter, since the period is a parameter
   int lineCnt_q;
   logic seen_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lineCnt_q <= 0;
         seen_q <= 1'h0;
      end else if (panel.linePulse) begin
         lineCnt_q <= 0;
         seen_q <= 1'h1;
      end else begin
         lineCnt_q <= lineCnt_q + 1;
      end
   end
   // ======
   // sequences and properties
   sequence s_wrTake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_fetchRun;
      fetch.fetchValid ##1 fetch.fetchValid;
   endsequence
   property p_linePeriod;
      seen_q && panel.linePulse |-> lineCnt_q == LINE_CYCLES - 1;
   endproperty
   a_linePeriod: assert property (p_linePeriod)
      else $error("line pulse period wrong");
   property p_lineGap;
      seen_q |-> lineCnt_q < LINE_CYCLES;
   endproperty
   a_lineGap: assert property (p_lineGap)
      else $error("line pulse missing");
   property p_frameOnLine;
      panel.framePulse |-> panel.linePulse;
   endproperty
   a_frameOnLine: assert property (p_frameOnLine)
      else $error("frame pulse without line pulse");
   property p_altOnPulse;
      $changed(panel.altDrive) |-> panel.linePulse;
   endproperty
   a_altOnPulse: assert property (p_altOnPulse)
      else $error("drive flipped off a line pulse");
   property p_fetchStep;
      s_fetchRun |-> fetch.fetchAddr == $past(fetch.fetchAddr) + 16'h1;
   endproperty
   a_fetchStep: assert property (p_fetchStep)
      else $error("fetch address did not step");
   property p_wrAnswer;
      s_wrTake |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wrAnswer: assert property (p_wrAnswer)
      else $error("write answer late");
   property p_awBlock;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   a_awBlock: assert property (p_awBlock)
      else $error("address ready after take");
   property p_bHold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bHold: assert property (p_bHold)
      else $error("write response dropped");
   property p_rdAnswer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rdAnswer: assert property (p_rdAnswer)
      else $error("read answer late");
endmodule // dssa_display_checker

bind dssa_display dssa_display_checker #(.LINE_CYCLES(LINE_CYCLES)) i_chk (
   .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .panel, .fetch);

// ===== dssa_panel_model.sv
// passive panel model measuring the alternating drive rhythm
`timescale 1ns/1ps
module dssa_panel_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire dssa_pkg::dssa_panel_t panel,
   output int togLines
);
   // ======
   // a panel only listens: line pulses between two drive flips
   int since;
   logic lastAlt;
   always @(posedge clk) begin
      if (!rst_n) begin
         since <= 0;
         togLines <= 0;
         lastAlt <= 1'h0;
      end else begin
         lastAlt <= panel.altDrive;
         if (panel.linePulse && panel.altDrive !== lastAlt) begin
            togLines <= since + 1;
            since <= 0;
         end else if (panel.linePulse) begin
            since <= since + 1;
         end
      end
   end
endmodule // dssa_panel_model

// ===== dssa_display_test.sv
// self-checking bench for the display addressing block
`timescale 1ns/1ps
`include "dssa_map.svh"
module dssa_display_test;
   // ======
   // signals and instances
   logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [`DSSA_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, pixelIndex;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   dssa_pkg::dssa_panel_t panel;
   dssa_pkg::dssa_fetch_t fetch;
   int errorCnt, testsRun, togLines;
   dssa_display #(.LINE_CYCLES(8), .ACTIVE_WORDS(4), .LINE_BYTES(80),
      .VBLANK_LINES(1)) i_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pixelIndex, .panel,
      .fetch);
   dssa_panel_model i_panel (.clk, .rst_n, .panel, .togLines);
   // ======
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] got, exp);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d,
         input logic [1:0] er = `DSSA_RESP_OKAY);
      logic a, w;
      a = 1'h1;
      w = 1'h1;
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (a || w) begin
         @(posedge clk);
         if (a && s_axi_awready) begin
            s_axi_awvalid <= 1'h0;
            a = 1'h0;
         end
         if (w && s_axi_wready) begin
            s_axi_wvalid <= 1'h0;
            w = 1'h0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", s_axi_bresp, er);
   endtask
   task automatic rdc(input string nm, input logic [15:0] idx,
         input logic [7:0] e, input logic [1:0] er = `DSSA_RESP_OKAY);
      @(posedge clk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(nm, s_axi_rdata, {24'h0, e});
      chk("rresp", s_axi_rresp, er);
   endtask
   // waits for n line pulses, or n frame pulses
   task automatic ev(input bit frm, input int n);
      repeat (n) do @(posedge clk);
         while (!(frm ? panel.framePulse : panel.linePulse));
   endtask
   // start addresses of the four visible lines of the frame that begins at the second frame pulse
   task automatic starts(input logic [63:0] exp);
      logic prev;
      int k;
      prev = 1'h0;
      k = 0;
      ev(1'h1, 2);
      while (k < 4) begin
         if (fetch.fetchValid && !prev) begin
            chk("line start", fetch.fetchAddr, exp[63-16*k -: 16]);
            k++;
         end
         prev = fetch.fetchValid;
         if (k < 4) @(posedge clk);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ======
   // scenarios
   task automatic t_lut;
      logic [11:0] px [3];
      px = '{12'h123, 12'h567, 12'h9AB};
      wr(`DSSA_IDX_LUT_PTR, 8'h00);
      for (int i = 1; i <= 3; i++) wr(`DSSA_IDX_LUT_DATA, 8'(i));
      for (int s = 1; s <= 3; s++) begin
         wr(`DSSA_IDX_LUT_PTR, {2'h0, 2'(s), 4'h1});
         wr(`DSSA_IDX_LUT_DATA, 8'(s + 4));
         wr(`DSSA_IDX_LUT_DATA, 8'(s + 8));
      end
      wr(`DSSA_IDX_LUT_PTR, 8'h00);
      for (int i = 1; i <= 3; i++) rdc("auto", `DSSA_IDX_LUT_DATA, 8'(i));
      wr(`DSSA_IDX_LUT_PTR, 8'h32);
      rdc("blue two", `DSSA_IDX_LUT_DATA, 8'h0B);
      for (int i = 0; i < 3; i++) begin
         pixelIndex <= 4'(i);
         repeat (2) @(posedge clk);
         chk("pixel", panel.pixel, px[i]);
      end
   endtask
   task automatic t_fetch;
      wr(`DSSA_IDX_VSIZE_LO, 8'h03);
      wr(`DSSA_IDX_S1_LO, 8'h10);
      wr(`DSSA_IDX_S1_HI, 8'h80);
      wr(`DSSA_IDX_S2_LO, 8'h00);
      wr(`DSSA_IDX_S2_HI, 8'h82);
      wr(`DSSA_IDX_OFFSET, 8'h02);
      wr(`DSSA_IDX_H1_LO, 8'h01);
      rdc("start hi", `DSSA_IDX_S1_HI, 8'h80);
      starts({16'h0010, 16'h0016, 16'h0200, 16'h0206});
      wr(`DSSA_IDX_H1_LO, 8'h03);
      starts({16'h0010, 16'h0016, 16'h001C, 16'h0022});
      wr(`DSSA_IDX_CTRL, 8'h02);
      starts({16'h8010, 16'h8060, 16'h80B0, 16'h8100});
   endtask
   task automatic t_alt;
      wr(`DSSA_IDX_CTRL, 8'h00);
      wr(`DSSA_IDX_ALT_RATE, 8'h00);
      ev(1'h0, 12);
      chk("lines per flip", togLines, 5);
      wr(`DSSA_IDX_ALT_RATE, 8'h02);
      ev(1'h0, 8);
      chk("lines per flip", togLines, 3);
      wr(`DSSA_IDX_CTRL, 8'h01);
      for (int i = 0; i < 6; i++) begin
         ev(1'h0, 1);
         chk("tft drive", panel.altDrive, 1'h0);
      end
   endtask
   // ======
   // clock, sequence, watchdog
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      pixelIndex = 4'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      rdc("height lo", `DSSA_IDX_H1_LO, 8'h00);
      rdc("height hi", `DSSA_IDX_H1_HI, 8'h00);
      wr(16'hFFEE, 8'h55, `DSSA_RESP_SLVERR);
      rdc("unmapped", 16'hFFEE, 8'h00, `DSSA_RESP_SLVERR);
      t_lut();
      t_fetch();
      t_alt();
      give_verdict();
   end
   initial begin
      #200000;
      errorCnt++;
      give_verdict();
   end
endmodule // dssa_display_test
